/* rtl/capture_channel.v */
// One capture channel: pin synchroniser, edge select and capture latch
`timescale 1ns/100ps
`include "timer2_defines.vh"

module capture_channel (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Pin and timing
	input  wire        pin_in,
	input  wire        sample_tick,
	input  wire        end_tick,
	// Edge selection and timer
	input  wire        rise_en,
	input  wire        fall_en,
	input  wire [15:0] timer_val,
	// Results
	output reg  [15:0] cap_r,
	output wire        load
);

reg meta_r;
reg sync_r;
reg last_r;
reg prime_r;
reg pend_r;

wire rise = sync_r & ~last_r & prime_r;
wire fall = ~sync_r & last_r & prime_r;

assign load = end_tick & pend_r;

always @(posedge mclk) begin
	if (!rst_n) begin
		meta_r  <= 1'b0;
		sync_r  <= 1'b0;
		last_r  <= 1'b0;
		prime_r <= 1'b0;
		pend_r  <= 1'b0;
		cap_r   <= `RST_WORD;
	end else begin
		meta_r <= pin_in;
		sync_r <= meta_r;
		if (sample_tick) begin
			last_r <= sync_r;
			pend_r <= (rise_en & rise) | (fall_en & fall); // [RULE7]
		end else if (end_tick) begin
			pend_r <= 1'b0;
		end
		// History follows the pin through the first machine cycle, so a
		// pin held high across reset gives no false edge
		if (!prime_r) begin
			last_r <= sync_r;
		end
		if (end_tick) begin
			prime_r <= 1'b1;
		end
		if (load) begin
			cap_r <= timer_val; // [RULE9]
		end
	end
end

endmodule

/* rtl/compare_channel.v */
// One compare channel: 16-bit compare value and match detection
`timescale 1ns/100ps
`include "timer2_defines.vh"

module compare_channel (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Byte writes
	input  wire        wr_lo,
	input  wire        wr_hi,
	input  wire [7:0]  wdata,
	// Match
	input  wire        arm,
	input  wire [15:0] timer_val,
	output reg  [15:0] cmp_r,
	output wire        hit
);

// Only the first end of cycle after an increment may hit
assign hit = arm & (timer_val == cmp_r); // [RULE10]

always @(posedge mclk) begin
	if (!rst_n) begin
		cmp_r <= `RST_WORD;
	end else begin
		if (wr_lo) begin
			cmp_r[7:0] <= wdata;
		end
		if (wr_hi) begin
			cmp_r[15:8] <= wdata;
		end
	end
end

endmodule

/* rtl/timer2_capture_compare.v */
// Timer with four capture and three compare channels and port 4 control
//
// Notes on behaviour
// RULE1 - Enable bits: 7 overflow, 6..4 comparators 2..0, 3..0 captures.
// RULE2 - Comparator request raised only while its enable bit is set.
// RULE3 - Timer control: selects, ext reset, byte flag, prescale, mode.
// RULE4 - Each capture input event loads timer value and flags request.
// RULE5 - Capture inputs are port 1 pins 0 to 3.
// RULE6 - Capture flags set even if value unused: extra interrupts.
// RULE7 - Rise, fall or both edges per channel from edge control bits.
// RULE8 - Inputs sampled once per machine cycle at state1_phase1; the ext reset pin edge is taken on every clock.
// RULE9 - Capture loads timer at end of the same machine cycle.
// RULE10 - Every new timer value is compared with three compare values.
// RULE11 - Compare flag set at end of machine cycle after the match.
// RULE12 - Compare 0 match sets port 4 bits 0..5 with set enable.
// RULE13 - Mode 01 clocks timer from oscillator divided by 12.
// RULE14 - Prescale 1,2,4,8; cleared on factor, source change, reset.
// RULE15 - Compare 1 match clears port 4 bits 0..5 with reset enable.
// RULE16 - Match beats software write; set and reset together clears.
// RULE17 - Mode 00 halts, 11 counts external pin, 10 reserved.
`timescale 1ns/100ps
`include "timer2_defines.vh"

module timer2_capture_compare (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Register port
	input  wire [7:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [7:0]  rdata_r,
	// Pins
	input  wire [7:0]  port1_in,
	output reg  [7:0]  port4_r,
	// Interrupt requests
	output reg  [3:0]  cap_irq_req_r,
	output reg  [2:0]  cmp_irq_req_r,
	output reg         ovf_irq_req_r
);

// ----------------------------------------------------------------------
// Registers and state
// ----------------------------------------------------------------------
reg  [7:0]  irq_en_r;
reg  [7:0]  tctrl_r;
reg  [7:0]  capedge_r;
reg  [7:0]  flags_r;
reg  [5:0]  seten_r;
reg  [1:0]  tg_r;
reg  [7:0]  rsten_r;
reg  [15:0] timer_r;
reg  [2:0]  pre_r;
reg  [3:0]  phase_r;
reg         inc_seen_r;
reg  [1:0]  cnt_meta_r;
reg  [1:0]  cnt_sync_r;
reg         cnt_last_r;
reg         cnt_pend_r;
reg         rst_last_r;

reg  [7:0]  tctrl_nxt;
reg  [7:0]  flags_nxt;
reg  [7:0]  port4_nxt;
reg  [1:0]  tg_nxt;
reg  [15:0] timer_nxt;
reg  [2:0]  pre_nxt;
reg         inc_seen_nxt;
reg  [7:0]  rd_nxt;
reg         src_tick;
reg         pre_wrap;
reg         do_inc;

wire        sample_tick = (phase_r == `MC_SAMPLE);
wire        end_tick    = (phase_r == `MC_LAST);
wire [1:0]  mode        = tctrl_r[`TC_MODE_HI:`TC_MODE_LO];
wire [1:0]  pre_sel     = tctrl_r[`TC_PRE_HI:`TC_PRE_LO];
wire        ext_rst     = tctrl_r[`TC_EXT_RST] & cnt_sync_r[1] &
                          ~rst_last_r;
wire [3:0]  cap_load;
wire [2:0]  cmp_hit;
wire [63:0] cap_all;
wire [47:0] cmp_all;
wire        wr_tctrl    = wr & (addr == `ADDR_TCTRL);
wire        cap_page    = (addr[7:3] == `CAP_PAGE);
wire        cmp_page    = (addr[7:3] == `CMP_PAGE);
// Set enable reset value, split into enable bits and toggle flip-flops
wire [7:0]  seten_init  = `SETEN_RST;

// ----------------------------------------------------------------------
// Machine cycle phase: twelve oscillator periods
// ----------------------------------------------------------------------
always @(posedge mclk) begin
	if (!rst_n) begin
		phase_r <= `MC_SAMPLE;
	end else if (end_tick) begin
		phase_r <= `MC_SAMPLE; // [RULE13]
	end else begin
		phase_r <= phase_r + 4'h1;
	end
end

// ----------------------------------------------------------------------
// Capture channels on port 1 pins 0..3
// ----------------------------------------------------------------------
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_cap
		capture_channel u_cap (
			.mclk        (mclk),
			.rst_n       (rst_n),
			.pin_in      (port1_in[gi]), // [RULE5]
			.sample_tick (sample_tick), // [RULE8]
			.end_tick    (end_tick),
			.rise_en     (capedge_r[2*gi]),
			.fall_en     (capedge_r[2*gi+1]),
			.timer_val   (timer_r),
			.cap_r       (cap_all[16*gi +: 16]),
			.load        (cap_load[gi])
		);
	end
endgenerate

// ----------------------------------------------------------------------
// Compare channels
// ----------------------------------------------------------------------
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
		compare_channel u_cmp (
			.mclk      (mclk),
			.rst_n     (rst_n),
			.wr_lo     (wr & cmp_page & (addr[2:1] == gi) & ~addr[0]),
			.wr_hi     (wr & cmp_page & (addr[2:1] == gi) & addr[0]),
			.wdata     (wdata),
			.arm       (end_tick & inc_seen_r),
			.timer_val (timer_r),
			.cmp_r     (cmp_all[16*gi +: 16]),
			.hit       (cmp_hit[gi])
		);
	end
endgenerate

// ----------------------------------------------------------------------
// External count and reset pins, synchronised
// ----------------------------------------------------------------------
always @(posedge mclk) begin
	if (!rst_n) begin
		cnt_meta_r <= 2'h0;
		cnt_sync_r <= 2'h0;
		cnt_last_r <= 1'b0;
		cnt_pend_r <= 1'b0;
		rst_last_r <= 1'b0;
	end else begin
		cnt_meta_r <= {port1_in[`P1_EXT_RST], port1_in[`P1_EXT_CNT]};
		cnt_sync_r <= cnt_meta_r;
		rst_last_r <= cnt_sync_r[1];
		// Count pin sampled once per machine cycle: one count at most
		if (sample_tick) begin
			cnt_last_r <= cnt_sync_r[0];
			cnt_pend_r <= cnt_sync_r[0] & ~cnt_last_r;
		end else if (end_tick) begin
			cnt_pend_r <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------------
// Prescaler and timer
// ----------------------------------------------------------------------
always @* begin
	case (mode)
		`MODE_OSC:  src_tick = end_tick; // [RULE13]
		`MODE_EXT:  src_tick = end_tick & cnt_pend_r; // [RULE17]
		`MODE_HALT: src_tick = 1'b0; // [RULE17]
		default:    src_tick = 1'b0;
	endcase
	case (pre_sel)
		`PRE_DIV1: pre_wrap = 1'b1; // [RULE14]
		`PRE_DIV2: pre_wrap = (pre_r[0] == 1'b1);
		`PRE_DIV4: pre_wrap = (pre_r[1:0] == 2'h3);
		`PRE_DIV8: pre_wrap = (pre_r == 3'h7);
		default:   pre_wrap = 1'b1;
	endcase
	do_inc    = src_tick & pre_wrap & ~ext_rst;
	timer_nxt = timer_r;
	pre_nxt   = pre_r;
	if (src_tick) begin
		pre_nxt = pre_wrap ? 3'h0 : pre_r + 3'h1;
	end
	if (do_inc) begin
		timer_nxt = timer_r + 16'h0001;
	end
	// A change of factor or source, or a timer reset, restarts the count
	if (wr_tctrl && (wdata[`TC_PRE_HI:`TC_MODE_LO] !=
	                 tctrl_r[`TC_PRE_HI:`TC_MODE_LO])) begin
		pre_nxt = 3'h0; // [RULE14]
	end
	if (ext_rst) begin
		timer_nxt = `RST_WORD;
		pre_nxt   = 3'h0; // [RULE14]
	end
	inc_seen_nxt = end_tick ? do_inc : inc_seen_r;
end

// ----------------------------------------------------------------------
// Flags: hardware set wins over software clear
// ----------------------------------------------------------------------
always @* begin
	tctrl_nxt = tctrl_r;
	if (wr_tctrl) begin
		tctrl_nxt = wdata; // [RULE3]
	end
	if (do_inc && (timer_r[7:0] == `BYTE_ALL1)) begin
		tctrl_nxt[`TC_BYTE_OVF] = 1'b1;
	end
	flags_nxt = flags_r;
	if (wr && (addr == `ADDR_FLAGS)) begin
		flags_nxt = wdata;
	end
	if (do_inc && (timer_r == `WORD_ALL1)) begin
		flags_nxt[`FLG_WIDE_OVF] = 1'b1;
	end
	// Capture flags set whether or not the value is read
	flags_nxt[`FLG_CAP0 +: 4] = flags_nxt[`FLG_CAP0 +: 4] |
	                            cap_load; // [RULE4] [RULE6]
	flags_nxt[`FLG_CMP0 +: 3] = flags_nxt[`FLG_CMP0 +: 3] |
	                            cmp_hit; // [RULE11]
end

// ----------------------------------------------------------------------
// Port 4: software write first, then compare actions override
// ----------------------------------------------------------------------
always @* begin
	port4_nxt = port4_r;
	tg_nxt    = tg_r;
	if (wr && (addr == `ADDR_PORT4)) begin
		port4_nxt = wdata;
	end
	if (cmp_hit[0]) begin
		port4_nxt[5:0] = port4_nxt[5:0] | (seten_r & `HW_MASK); // [RULE12]
	end
	// Clear applied last so a set and reset together leaves zero
	if (cmp_hit[1]) begin
		port4_nxt[5:0] = port4_nxt[5:0] &
		                 ~(rsten_r[5:0] & `HW_MASK); // [RULE15] [RULE16]
	end
	// Toggles follow their own flip-flops, not the port latch
	if (cmp_hit[2] && rsten_r[`TG_LO]) begin
		port4_nxt[`TG_LO] = tg_r[0]; // [RULE16]
		tg_nxt[0]         = ~tg_r[0];
	end
	if (cmp_hit[2] && rsten_r[`TG_HI]) begin
		port4_nxt[`TG_HI] = tg_r[1];
		tg_nxt[1]         = ~tg_r[1];
	end
end

// ----------------------------------------------------------------------
// Read multiplexer, data one cycle after the strobe
// ----------------------------------------------------------------------
always @* begin
	rd_nxt = `RST_BYTE;
	if (cap_page) begin
		rd_nxt = cap_all[{addr[2:0], 3'h0} +: 8];
	end else if (cmp_page && (addr[2:1] != 2'h3)) begin
		rd_nxt = cmp_all[{addr[2:0], 3'h0} +: 8];
	end else begin
		case (addr)
			`ADDR_IRQ_EN:  rd_nxt = irq_en_r;
			`ADDR_TCTRL:   rd_nxt = tctrl_r;
			`ADDR_CAPEDGE: rd_nxt = capedge_r;
			`ADDR_FLAGS:   rd_nxt = flags_r;
			`ADDR_SETEN:   rd_nxt = {tg_r, seten_r};
			`ADDR_RSTEN:   rd_nxt = rsten_r;
			`ADDR_TMR_LO:  rd_nxt = timer_r[7:0];
			`ADDR_TMR_HI:  rd_nxt = timer_r[15:8];
			`ADDR_PORT4:   rd_nxt = port4_r;
			default:       rd_nxt = `RST_BYTE;
		endcase
	end
end

// ----------------------------------------------------------------------
// State update
// ----------------------------------------------------------------------
always @(posedge mclk) begin
	if (!rst_n) begin
		irq_en_r      <= `RST_BYTE; // [RULE1]
		tctrl_r       <= `RST_BYTE; // [RULE3]
		capedge_r     <= `RST_BYTE;
		flags_r       <= `RST_BYTE;
		seten_r       <= seten_init[5:0];
		tg_r          <= seten_init[`TG_HI:`TG_LO];
		rsten_r       <= `RST_BYTE;
		timer_r       <= `RST_WORD;
		pre_r         <= 3'h0;
		inc_seen_r    <= 1'b0;
		port4_r       <= `PORT4_RST;
		rdata_r       <= `RST_BYTE;
		cap_irq_req_r <= 4'h0;
		cmp_irq_req_r <= 3'h0;
		ovf_irq_req_r <= 1'b0;
	end else begin
		if (wr && (addr == `ADDR_IRQ_EN)) begin
			irq_en_r <= wdata; // [RULE1]
		end
		if (wr && (addr == `ADDR_CAPEDGE)) begin
			capedge_r <= wdata; // [RULE7]
		end
		if (wr && (addr == `ADDR_SETEN)) begin
			seten_r <= wdata[5:0];
		end
		if (wr && (addr == `ADDR_RSTEN)) begin
			rsten_r <= wdata;
		end
		tctrl_r    <= tctrl_nxt;
		flags_r    <= flags_nxt;
		timer_r    <= timer_nxt;
		pre_r      <= pre_nxt;
		inc_seen_r <= inc_seen_nxt;
		port4_r    <= port4_nxt;
		tg_r       <= tg_nxt;
		if (rd) begin
			rdata_r <= rd_nxt;
		end else begin
			rdata_r <= `RST_BYTE;
		end
		// Requests follow flags gated by their enables
		cap_irq_req_r <= flags_r[`FLG_CAP0 +: 4] &
		                 irq_en_r[`IEN_CAP0 +: 4]; // [RULE1] [RULE6]
		cmp_irq_req_r <= flags_r[`FLG_CMP0 +: 3] &
		                 irq_en_r[`IEN_CMP0 +: 3]; // [RULE2]
		ovf_irq_req_r <= irq_en_r[`IEN_OVF] &
		                 ((tctrl_r[`TC_WIDE_SEL] & flags_r[`FLG_WIDE_OVF]) |
		                  (tctrl_r[`TC_BYTE_SEL] &
		                   tctrl_r[`TC_BYTE_OVF])); // [RULE1]
	end
end

endmodule

/* rtl/timer2_defines.vh */
// Constants shared by the timer, capture and compare logic
`ifndef TIMER2_DEFINES_VH
`define TIMER2_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_IRQ_EN    8'hE8
`define ADDR_TCTRL     8'hEA
`define ADDR_CAPEDGE   8'hEB
`define ADDR_FLAGS     8'hC8
`define ADDR_SETEN     8'hEE
`define ADDR_RSTEN     8'hEF
`define ADDR_TMR_LO    8'hC0
`define ADDR_TMR_HI    8'hC1
`define ADDR_PORT4     8'hC2
// Capture bytes at A0..A7, compare bytes at B0..B5 (low byte first)
`define CAP_PAGE       5'h14
`define CMP_PAGE       5'h16

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TC_WIDE_SEL    7
`define TC_BYTE_SEL    6
`define TC_EXT_RST     5
`define TC_BYTE_OVF    4
`define TC_PRE_HI      3
`define TC_PRE_LO      2
`define TC_MODE_HI     1
`define TC_MODE_LO     0
`define IEN_OVF        7
`define IEN_CMP0       4
`define IEN_CAP0       0
`define FLG_WIDE_OVF   7
`define FLG_CMP0       4
`define FLG_CAP0       0
`define P1_EXT_CNT     4
`define P1_EXT_RST     5
`define TG_LO          6
`define TG_HI          7

// ----------------------------------------------------------------------
// Encodings, reset values, timing
// ----------------------------------------------------------------------
`define MODE_HALT      2'h0
`define MODE_OSC       2'h1
`define MODE_RSVD      2'h2
`define MODE_EXT       2'h3
`define PRE_DIV1       2'h0
`define PRE_DIV2       2'h1
`define PRE_DIV4       2'h2
`define PRE_DIV8       2'h3
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
`define SETEN_RST      8'hC0
`define PORT4_RST      8'h00
`define HW_MASK        6'h3F
// Machine cycle is 12 oscillator periods; phase 0 is state1_phase1
`define MC_SAMPLE      4'h0
`define MC_LAST        4'hB
`define BYTE_ALL1      8'hFF
`define WORD_ALL1      16'hFFFF

`endif

/* verification/event_source.sv */
// Far-side model driving the capture pins of port 1
`timescale 1ns/100ps
module event_source (
	// Clock
	input  wire       mclk,
	// Requested levels
	input  wire [5:0] ev_lvl,
	// Port 1 pins
	output reg  [7:0] port1_pins
);
	initial port1_pins = 8'h00;
	// Bits 5:4 are the timer reset and count pins; bits 7:6 stay low
	always @(posedge mclk) begin
		port1_pins <= {2'h0, ev_lvl};
	end
endmodule

/* verification/test_timer2_capture_compare.sv */
// Self-checking bench for the timer capture and compare block
`timescale 1ns/100ps
module test_timer2_capture_compare;
	reg         mclk, rst_n, wr, rd;
	reg  [7:0]  addr, wdata, v, t0, t1;
	reg  [5:0]  ev_lvl;
	wire [7:0]  rdata_r, port1_in, port4_r;
	wire [3:0]  cap_irq_req_r;
	wire [2:0]  cmp_irq_req_r;
	wire        ovf_irq_req_r;
	integer     error_cnt = 0, check_count = 0, i, ch, m;
	reg  [63:0] ra = 64'hE8EAEBC8EEEFC210;
	reg  [63:0] rv = 64'h00000000C0000000;

	timer2_capture_compare DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
		.port1_in(port1_in), .port4_r(port4_r),
		.cap_irq_req_r(cap_irq_req_r), .cmp_irq_req_r(cmp_irq_req_r),
		.ovf_irq_req_r(ovf_irq_req_r));
	event_source partner (.mclk(mclk), .ev_lvl(ev_lvl),
		.port1_pins(port1_in));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task close_out;
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task check(input string what, input [7:0] exp, input [7:0] got);
		check_count = check_count + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED %0s exp %h got %h", what, exp, got);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	task wr_reg(input [7:0] a, input [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd_reg(input [7:0] a, output [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		d = rdata_r;
	endtask

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		ev_lvl = 6'h00;
		cyc(12);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			rd_reg(ra[63 - 8 * i -: 8], v);
			check("reset value", rv[63 - 8 * i -: 8], v);
		end
		wr_reg(8'hE8, 8'hA5);
		rd_reg(8'hE8, v);
		check("irq enable", 8'hA5, v);
		wr_reg(8'hEB, 8'h5A);
		rd_reg(8'hEB, v);
		check("edge control", 8'h5A, v);
		wr_reg(8'hEA, 8'hEE);
		rd_reg(8'hEA, v);
		check("timer control", 8'hEE, v);
		// Windows of 8 machine cycles hold exactly 8/N increments in mode 01, none in modes 00 and 10
		for (i = 0; i < 6; i = i + 1) begin
			wr_reg(8'hEA, (i < 4) ? 8'(i * 4 + 1) : 8'(i * 2 - 8));
			cyc(30);
			rd_reg(8'hC0, t0);
			cyc(93);
			rd_reg(8'hC0, t1);
			check("timer step", (i < 4) ? 8'(8 >> i) : 8'h00, t1 - t0);
		end
		wr_reg(8'hE8, 8'h05);
		for (ch = 0; ch < 4; ch = ch + 1) begin
			for (m = 1; m < 4; m = m + 1) begin
				wr_reg(8'hEB, 8'(m << (2 * ch)));
				wr_reg(8'hC8, 8'h00);
				ev_lvl[ch] <= 1'b1;
				cyc(40);
				rd_reg(8'hC8, v);
				check("rise flag", (m & 1) ? 8'h01 << ch : 8'h00, v);
				check("cap request", (m & 1) && !ch[0] ? 8'h01 << ch : 8'h00, {4'h0, cap_irq_req_r});
				wr_reg(8'hC8, 8'h00);
				ev_lvl[ch] <= 1'b0;
				cyc(40);
				rd_reg(8'hC8, v);
				check("fall flag", (m & 2) ? 8'h01 << ch : 8'h00, v);
			end
		end
		wr_reg(8'hEA, 8'h01);
		wr_reg(8'hEB, 8'h01);
		rd_reg(8'hC0, t0);
		ev_lvl[0] <= 1'b1;
		cyc(40);
		rd_reg(8'hA0, v);
		check("capture time", 8'h01, {7'h00, (v - t0) < 8'h04});
		rd_reg(8'hA1, v);
		check("capture high", 8'h00, v);
		wr_reg(8'hE8, 8'h10);
		wr_reg(8'hEE, 8'h0F);
		wr_reg(8'hEF, 8'h03);
		rd_reg(8'hC0, t0);
		wr_reg(8'hB0, t0 + 8'h08);
		wr_reg(8'hB1, 8'h00);
		wr_reg(8'hB2, t0 + 8'h10);
		wr_reg(8'hB3, 8'h00);
		wr_reg(8'hC8, 8'h00);
		cyc(130);
		check("port after set", 8'h0F, port4_r);
		cyc(100);
		check("port after clear", 8'h0C, port4_r);
		rd_reg(8'hC8, v);
		check("compare flags", 8'h30, v);
		check("cmp request", 8'h01, {5'h00, cmp_irq_req_r});
		wr_reg(8'hC2, 8'h3C);
		cyc(1);
		check("port write", 8'h3C, port4_r);
		wr_reg(8'hEE, 8'h30);
		wr_reg(8'hEF, 8'h30);
		rd_reg(8'hC0, t0);
		wr_reg(8'hB0, t0 + 8'h08);
		wr_reg(8'hB2, t0 + 8'h08);
		cyc(200);
		check("set and clear", 8'h0C, port4_r);
		// External count pin: each rising edge is one count
		wr_reg(8'hEA, 8'h03);
		rd_reg(8'hC0, t0);
		for (i = 0; i < 4; i = i + 1) begin
			ev_lvl[4] <= 1'b1;
			cyc(30);
			ev_lvl[4] <= 1'b0;
			cyc(30);
		end
		rd_reg(8'hC0, t1);
		check("count pin", 8'h04, t1 - t0);
		// External timer reset, then no counts while the pin stays low
		wr_reg(8'hEA, 8'h23);
		ev_lvl[5] <= 1'b1;
		cyc(30);
		rd_reg(8'hC0, t0);
		rd_reg(8'hC1, t1);
		check("ext reset", 8'h00, t0 | t1);
		ev_lvl[5] <= 1'b0;
		// From zero, 256 increments wrap the low byte
		wr_reg(8'hE8, 8'h80);
		wr_reg(8'hEA, 8'h41);
		cyc(3200);
		rd_reg(8'hEA, v);
		check("byte overflow", 8'h51, v);
		check("ovf request", 8'h01, {7'h00, ovf_irq_req_r});
		close_out;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt = error_cnt + 1;
		close_out;
	end
endmodule

bind timer2_capture_compare timer2_cc_properties u_props (
	.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata_r(rdata_r), .port1_in(port1_in), .port4_r(port4_r),
	.cap_irq_req_r(cap_irq_req_r), .cmp_irq_req_r(cmp_irq_req_r),
	.ovf_irq_req_r(ovf_irq_req_r));

/* verification/timer2_cc_properties.sv */
// Port assertions for the timer capture and compare block
`timescale 1ns/100ps
module timer2_cc_properties (
	// Clock and reset
	input wire       mclk,
	input wire       rst_n,
	// Register port
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire       wr,
	input wire       rd,
	input wire [7:0] rdata_r,
	// Pins and requests
	input wire [7:0] port1_in,
	input wire [7:0] port4_r,
	input wire [3:0] cap_irq_req_r,
	input wire [2:0] cmp_irq_req_r,
	input wire       ovf_irq_req_r
);
	// ------------------------------------------------------------------
	// Register mirrors and pin age
	// ------------------------------------------------------------------
	reg [7:0] ien_m, tc_m, ce_m;
	reg [5:0] se_m, rt_m, age_r;
	reg [3:0] pin_q;

	// Age saturates so a long quiet pin never wraps back to young
	always @(posedge mclk) begin
		pin_q <= port1_in[3:0];
		if (!rst_n || pin_q != port1_in[3:0])
			age_r <= 6'h00;
		else if (age_r != 6'h3F)
			age_r <= age_r + 6'h01;
		if (!rst_n) begin
			ien_m <= 8'h00;
			tc_m <= 8'h00;
			ce_m <= 8'h00;
			se_m <= 6'h00;
			rt_m <= 6'h00;
		end else if (wr) begin
			case (addr)
			8'hE8: ien_m <= wdata;
			8'hEA: tc_m <= wdata;
			8'hEB: ce_m <= wdata;
			8'hEE: se_m <= wdata[5:0];
			8'hEF: rt_m <= wdata[5:0];
			default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	property p_ien_rd;
		$past(rd && addr == 8'hE8) |-> rdata_r == $past(ien_m);
	endproperty
	a_ien_rd: assert property (p_ien_rd)
		else $error("irq enable read mismatch");
	property p_tc_rd;
		$past(rd && addr == 8'hEA) |->
			(rdata_r & 8'hEF) == ($past(tc_m) & 8'hEF);
	endproperty
	a_tc_rd: assert property (p_tc_rd)
		else $error("timer control read mismatch");
	property p_ce_rd;
		$past(rd && addr == 8'hEB) |-> rdata_r == $past(ce_m);
	endproperty
	a_ce_rd: assert property (p_ce_rd)
		else $error("edge control read mismatch");
	property p_cmp_gate;
		(cmp_irq_req_r & ~$past(ien_m[6:4])) == 3'h0;
	endproperty
	a_cmp_gate: assert property (p_cmp_gate)
		else $error("compare request while disabled");
	property p_cap_gate;
		(cap_irq_req_r & ~$past(ien_m[3:0])) == 4'h0;
	endproperty
	a_cap_gate: assert property (p_cap_gate)
		else $error("capture request while disabled");
	property p_ovf_gate;
		ovf_irq_req_r |-> $past(ien_m[7]);
	endproperty
	a_ovf_gate: assert property (p_ovf_gate)
		else $error("overflow request while disabled");
	property p_p4_set;
		(port4_r[5:0] & ~$past(port4_r[5:0]) & ~$past(se_m)) != 6'h00
			|-> $past(wr && addr == 8'hC2);
	endproperty
	a_p4_set: assert property (p_p4_set)
		else $error("port bit set without enable");
	property p_p4_clr;
		(~port4_r[5:0] & $past(port4_r[5:0]) & ~$past(rt_m)) != 6'h00
			|-> $past(wr && addr == 8'hC2);
	endproperty
	a_p4_clr: assert property (p_p4_clr)
		else $error("port bit cleared without enable");
	property p_cap_src;
		(cap_irq_req_r & ~$past(cap_irq_req_r) & $past(ien_m[3:0], 2))
			!= 4'h0 |-> age_r < 6'h28;
	endproperty
	a_cap_src: assert property (p_cap_src)
		else $error("capture request without pin edge");

	c_cap: cover property ($rose(cap_irq_req_r[0]));
	c_cmp: cover property ($rose(cmp_irq_req_r[0]));
	c_p4: cover property (port4_r != $past(port4_r));
endmodule
